// file: gdfr_pkg.sv
// ---------------------------------------------------------------
// Contract
// - every reserved bit resets to zero
// - register bank exists only on the serial variant
// - status registers are read-only; writes to them change nothing
// - primary fault status sits at address zero, all eleven bits reset to zero
// - bit 10 is the OR of all fault flags and mirrors the alarm pin
// - bit 9 set on any drain-source overcurrent
// - bit 8 set on gate drive failure
// - bit 7 flags supply undervoltage lockout, bit 6 overtemperature shutdown
// - bits 5..0 flag per-FET overcurrent: A high, A low, B, C pairs
// - every field's default is its value after reset
// - frame is 16 bits: rw, 4-bit address, 11 data; device returns register
// - writing one to the clear bit clears latched flags, bit self-clears
// ---------------------------------------------------------------
package gdfr_pkg;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W   = 11;
  localparam int unsigned FRAME_W  = 16;
  localparam int unsigned NUM_REGS = 8;
  localparam logic [4:0]  CMD_LAST_BIT   = 5'h04;
  localparam logic [4:0]  FRAME_LAST_BIT = 5'h0f;
  localparam logic [4:0]  BITS_PER_FRAME = 5'h10;
  localparam logic        WRITE_OP = 1'b0;
  localparam logic        READ_OP  = 1'b1;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_PRIMARY_FAULT = 4'h0;
  localparam logic [3:0] ADDR_GATE_SENSE    = 4'h1;
  localparam logic [3:0] ADDR_DRIVER_CTRL   = 4'h2;
  localparam logic [3:0] ADDR_HS_DRIVE      = 4'h3;
  localparam logic [3:0] ADDR_LS_DRIVE      = 4'h4;
  localparam logic [3:0] ADDR_OCP_CTRL      = 4'h5;
  localparam logic [3:0] ADDR_CSA_CTRL      = 4'h6;
  localparam logic [3:0] ADDR_SENSE_CAL     = 4'h7;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned BIT_FAULT    = 10;
  localparam int unsigned BIT_VDS      = 9;
  localparam int unsigned BIT_GATE_FAIL = 8;
  localparam int unsigned BIT_UNDERVOLT = 7;
  localparam int unsigned BIT_OVERTEMP = 6;
  localparam int unsigned BIT_GS_OTW   = 7;
  localparam int unsigned BIT_CLEAR    = 0;
  localparam int unsigned BIT_OTW_REP  = 7;
  localparam int unsigned BIT_GATE_MASK = 8;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [10:0] RST_STATUS      = 11'h000;
  localparam logic [10:0] RST_DRIVER_CTRL = 11'h000;
  localparam logic [10:0] RST_HS_DRIVE    = 11'h3ff;
  localparam logic [10:0] RST_LS_DRIVE    = 11'h000;
  localparam logic [10:0] RST_OCP_CTRL    = 11'h000;
  localparam logic [10:0] RST_CSA_CTRL    = 11'h000;
  localparam logic [10:0] RST_SENSE_CAL   = 11'h000;
  localparam logic [5:0][10:0] CTRL_RST = {RST_SENSE_CAL, RST_CSA_CTRL, RST_OCP_CTRL,
                                           RST_LS_DRIVE, RST_HS_DRIVE, RST_DRIVER_CTRL};

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       rw;
    logic [3:0] addr;
    logic [10:0] data;
  } gdfr_frame_t;

  // fet_ocp[5] is phase a high side, fet_ocp[0] phase c low side
  typedef struct packed {
    logic [5:0] fet_ocp;
    logic       gate_fail;
    logic       supply_undervoltage_lockout;
    logic       overtemperature_shutdown;
  } gdfr_fault_t;

  typedef enum logic {ST_IDLE, ST_PEND} gdfr_commit_t;

endpackage

// file: gdfr_sync.sv
module gdfr_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  // data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // gdfr_sync

// file: gdfr_spi_link.sv
module gdfr_spi_link (
  // link clock and reset
  input  wire logic                     sclk_i,
  input  wire logic                     rstn_i,
  // serial pins
  input  wire logic                     cs_n_i,
  input  wire logic                     sdi_i,
  output logic                          sdo_oe_o,
  // core side
  input  wire logic [7:0][10:0]         snap_i,
  output gdfr_pkg::gdfr_frame_t         frame_o,
  output logic                          frame_tgl_o,
  output logic                          overrun_o
);
  import gdfr_pkg::*;

  logic        frame_rst_n;
  logic [4:0]  bit_cnt;
  logic [14:0] shift_in;
  logic [15:0] shift_out;
  logic [3:0]  rd_addr;
  logic [10:0] rd_word;

  // ---------------------------------------------------------------
  // frame scope: sclk stops outside frames, so cs ends the frame
  // ---------------------------------------------------------------
  assign frame_rst_n = rstn_i & ~cs_n_i;
  assign rd_addr     = {shift_in[2:0], sdi_i};
  assign rd_word     = rd_addr[3] ? '0 : snap_i[rd_addr[2:0]];

  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt  <= '0;
      shift_in <= '0;
    end else begin
      if (bit_cnt != BITS_PER_FRAME) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
      shift_in <= {shift_in[13:0], sdi_i};
    end
  end

  // address is known at the fifth falling edge, data leaves from the sixth rise
  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_out <= '0;
    end else if (bit_cnt == CMD_LAST_BIT) begin
      shift_out <= {5'h00, rd_word};
    end
  end

  // open drain: enable pulls the line low for a zero bit
  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sdo_oe_o <= 1'b0;
    end else begin
      sdo_oe_o <= ~bit_cnt[4] & ~shift_out[~bit_cnt[3:0]];
    end
  end

  // ---------------------------------------------------------------
  // hand-off: word held stable until the next full frame
  // ---------------------------------------------------------------
  always_ff @(negedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_o     <= '0;
      frame_tgl_o <= 1'b0;
    end else if (!cs_n_i && bit_cnt == FRAME_LAST_BIT) begin
      frame_o     <= {shift_in, sdi_i};
      frame_tgl_o <= ~frame_tgl_o;
    end
  end

  // a seventeenth edge marks the frame as broken
  always_ff @(negedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      overrun_o <= 1'b0;
    end else if (!cs_n_i && bit_cnt == 5'h00) begin
      overrun_o <= 1'b0;
    end else if (!cs_n_i && bit_cnt == BITS_PER_FRAME) begin
      overrun_o <= 1'b1;
    end
  end
endmodule // gdfr_spi_link

// file: gdfr_fault_regs.sv
module gdfr_fault_regs #(
  parameter bit HAS_SERIAL = 1'b1
) (
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rstn_i,
  // device enable pin, low means sleep
  input  wire logic                  enable_i,
  // fault detectors
  input  wire gdfr_pkg::gdfr_fault_t faults_i,
  input  wire logic [10:0]           gate_sense_i,
  // serial link
  input  wire logic                  spi_sclk_i,
  input  wire logic                  spi_cs_n_i,
  input  wire logic                  spi_sdi_i,
  output logic                       spi_sdo_o,
  output logic                       spi_sdo_oe_o,
  // alarm pin, open drain
  output logic                       alarm_out_n_o,
  output logic                       alarm_out_n_oe_o,
  // configuration to the driver
  output logic [5:0][10:0]           control_regs_o,
  output logic                       latched_error_clear_o
);
  import gdfr_pkg::*;

  localparam int unsigned SYNC_W = 4 + $bits(gdfr_fault_t) + DATA_W;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] sync_d;
  logic [SYNC_W-1:0] sync_q;
  logic              en_s;
  logic              cs_idle;
  logic              tgl_s;
  logic              ovr_s;
  gdfr_fault_t       flt_s;
  logic [10:0]       gs_s;
  logic              tgl_d;
  logic              tgl_edge;
  logic              sleep;
  logic              link_tgl;
  logic              link_ovr;
  logic              link_oe;
  gdfr_frame_t       frame;
  gdfr_commit_t      st;
  gdfr_commit_t      next_st;
  logic              commit;
  logic              wr_en;
  logic [5:0]        fet;
  logic              gate_flag;
  logic              uv_flag;
  logic              ot_flag;
  logic [10:0]       gss;
  logic [10:0]       status_w;
  logic              gate_mask;
  logic              otw_rep;
  logic              clr_pulse;
  logic [5:0][10:0]  ctrl_q;
  logic [7:0][10:0]  live;
  logic [7:0][10:0]  snap;

  // ---------------------------------------------------------------
  // pin and link crossings
  // ---------------------------------------------------------------
  assign sync_d = {enable_i, spi_cs_n_i, link_tgl, link_ovr, faults_i, gate_sense_i};

  gdfr_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_i  (core_clk_i),
    .rstn_i (rstn_i),
    .d_i    (sync_d),
    .q_o    (sync_q)
  );

  assign {en_s, cs_idle, tgl_s, ovr_s, flt_s, gs_s} = sync_q;
  assign sleep    = ~en_s;
  assign tgl_edge = tgl_s ^ tgl_d;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tgl_d <= 1'b0;
    end else begin
      tgl_d <= tgl_s;
    end
  end

  // ---------------------------------------------------------------
  // serial engine on the link clock
  // ---------------------------------------------------------------
  gdfr_spi_link u_link (
    .sclk_i      (spi_sclk_i),
    .rstn_i      (rstn_i),
    .cs_n_i      (spi_cs_n_i),
    .sdi_i       (spi_sdi_i),
    .sdo_oe_o    (link_oe),
    .snap_i      (snap),
    .frame_o     (frame),
    .frame_tgl_o (link_tgl),
    .overrun_o   (link_ovr)
  );

  // hardware-strapped parts never answer on the serial pins
  assign spi_sdo_o    = 1'b0;
  assign spi_sdo_oe_o = HAS_SERIAL & link_oe;

  // ---------------------------------------------------------------
  // commit: wait for cs to rise so a long frame can be rejected
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    case (st)
      ST_IDLE: begin
        if (tgl_edge) begin
          next_st = ST_PEND;
        end
      end
      ST_PEND: begin
        if (cs_idle) begin
          next_st = ST_IDLE;
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // frame word is quasi-static here: the link only rewrites it after a new 16 edges
  assign commit = HAS_SERIAL && st == ST_PEND && cs_idle && !ovr_s && !sleep;
  assign wr_en  = commit && frame.rw == WRITE_OP
                  && frame.addr >= ADDR_DRIVER_CTRL
                  && frame.addr <= ADDR_SENSE_CAL;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  for (genvar k = 0; k < 6; k++) begin : g_ctrl
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        ctrl_q[k] <= CTRL_RST[k];
      end else if (sleep) begin
        ctrl_q[k] <= CTRL_RST[k];
      end else if (wr_en && frame.addr == 4'(k + 2)) begin
        ctrl_q[k] <= (k == 0) ? (frame.data & ~11'h001) : frame.data;
      end
    end
  end

  // clear request is a single pulse; the stored bit always reads back zero
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clr_pulse <= 1'b0;
    end else begin
      clr_pulse <= wr_en && frame.addr == ADDR_DRIVER_CTRL && frame.data[BIT_CLEAR];
    end
  end

  assign gate_mask             = ctrl_q[0][BIT_GATE_MASK];
  assign otw_rep               = ctrl_q[0][BIT_OTW_REP];
  assign control_regs_o        = ctrl_q;
  assign latched_error_clear_o = clr_pulse;

  // ---------------------------------------------------------------
  // fault flags
  // ---------------------------------------------------------------
  // a detector that fires in the clearing cycle keeps its flag
  for (genvar i = 0; i < 6; i++) begin : g_fet
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        fet[i] <= 1'b0;
      end else if (sleep) begin
        fet[i] <= 1'b0;
      end else if (flt_s.fet_ocp[i]) begin
        fet[i] <= 1'b1;
      end else if (clr_pulse) begin
        fet[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gate_flag <= 1'b0;
    end else if (sleep) begin
      gate_flag <= 1'b0;
    end else if (flt_s.gate_fail && !gate_mask) begin
      gate_flag <= 1'b1;
    end else if (clr_pulse) begin
      gate_flag <= 1'b0;
    end
  end

  // undervoltage, overtemperature and the second status word recover on their own
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      uv_flag <= 1'b0;
      ot_flag <= 1'b0;
      gss     <= RST_STATUS;
    end else begin
      uv_flag <= flt_s.supply_undervoltage_lockout;
      ot_flag <= flt_s.overtemperature_shutdown;
      gss     <= gs_s;
    end
  end

  assign status_w[5:0]          = fet;
  assign status_w[BIT_OVERTEMP]  = ot_flag;
  assign status_w[BIT_UNDERVOLT] = uv_flag;
  assign status_w[BIT_GATE_FAIL] = gate_flag;
  assign status_w[BIT_VDS]  = |fet;
  // warning only counts when software asks for it to be reported
  assign status_w[BIT_FAULT] = |status_w[9:6] | |gss[10:8] | |gss[6:0]
                               | (gss[BIT_GS_OTW] & otw_rep);

  assign alarm_out_n_o    = 1'b0;
  assign alarm_out_n_oe_o = status_w[BIT_FAULT];

  // ---------------------------------------------------------------
  // read snapshot, frozen for the whole frame
  // ---------------------------------------------------------------
  assign live = {ctrl_q, gss, status_w};

  // cs must fall at least three core cycles before the fifth falling sclk edge
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      snap <= '0;
    end else if (cs_idle) begin
      snap <= live;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence frame_arrives;
    st == ST_IDLE && tgl_edge;
  endsequence

  sequence frame_closes;
    st == ST_PEND && cs_idle;
  endsequence

  sequence clear_written;
    wr_en && frame.addr == ADDR_DRIVER_CTRL && frame.data[BIT_CLEAR];
  endsequence

  sequence clear_quiet;
    flt_s.fet_ocp == 6'h00 && !flt_s.gate_fail && !sleep;
  endsequence

  fault_mirror_a: assert property (
    alarm_out_n_oe_o == status_w[BIT_FAULT] && alarm_out_n_o == 1'b0)
    else $error("alarm pin does not mirror the summary bit");

  fault_summary_a: assert property (
    (status_w[9:6] != 4'h0) |-> status_w[BIT_FAULT])
    else $error("category flag set without summary bit");

  vds_summary_a: assert property (
    status_w[BIT_VDS] == (status_w[5:0] != 6'h00))
    else $error("overcurrent summary disagrees with per-fet flags");

  gate_fail_set_a: assert property (
    flt_s.gate_fail && !gate_mask && !sleep |=> status_w[BIT_GATE_FAIL]
      ##1 (status_w[BIT_GATE_FAIL] || $past(clr_pulse || sleep)))
    else $error("gate drive failure not flagged");

  uv_ot_follow_a: assert property (
    !sleep |=> status_w[BIT_UNDERVOLT] == $past(flt_s.supply_undervoltage_lockout)
               && status_w[BIT_OVERTEMP] == $past(flt_s.overtemperature_shutdown))
    else $error("undervoltage or overtemperature flag lags its detector");

  for (genvar i = 0; i < 6; i++) begin : g_fet_chk
    fet_set_a: assert property (
      flt_s.fet_ocp[i] && !sleep |=> status_w[i])
      else $error("per-fet overcurrent not flagged");

    fet_hold_a: assert property (
      status_w[i] && !clr_pulse && !sleep |=> status_w[i])
      else $error("per-fet flag dropped without a clear");
  end

  clear_flags_a: assert property (
    clear_written ##1 clear_quiet |=> status_w[5:0] == 6'h00 && !status_w[BIT_GATE_FAIL])
    else $error("clear did not remove latched flags");

  clear_self_a: assert property (
    !ctrl_q[0][BIT_CLEAR] && (!clr_pulse || $past(wr_en)))
    else $error("clear bit stored or pulse without a write");

  ctrl_stable_a: assert property (
    !wr_en && !sleep |=> ctrl_q == $past(ctrl_q))
    else $error("control register changed without a write");

  ctrl_write_a: assert property (
    wr_en && frame.addr == ADDR_HS_DRIVE |=> ctrl_q[1] == $past(frame.data))
    else $error("write data not taken");

  sleep_default_a: assert property (
    sleep |=> ctrl_q == CTRL_RST && status_w[5:0] == 6'h00 && !status_w[BIT_GATE_FAIL])
    else $error("sleep did not restore defaults");

  commit_walk_a: assert property (
    frame_arrives ##1 frame_closes |=> st == ST_IDLE)
    else $error("frame commit did not complete");

  pend_entry_a: assert property (
    frame_arrives |=> st == ST_PEND)
    else $error("frame arrival missed");

  snap_freeze_a: assert property (
    !cs_idle |=> snap == $past(snap))
    else $error("read snapshot moved during a frame");

  serial_only_a: assert property (
    !HAS_SERIAL |-> !wr_en && !spi_sdo_oe_o)
    else $error("register access on a hardware variant");

  clear_pulse_a: assert property (
    clear_written |=> latched_error_clear_o)
    else $error("clear write gave no pulse");

  status_ro_a: assert property (
    commit && frame.addr <= ADDR_GATE_SENSE |-> !wr_en)
    else $error("status register accepted a write");

  unmapped_quiet_a: assert property (
    commit && frame.addr[3] |-> !wr_en)
    else $error("unmapped address accepted a write");

  gate_mask_a: assert property (
    gate_mask && !status_w[BIT_GATE_FAIL] && !sleep |=> !status_w[BIT_GATE_FAIL])
    else $error("masked gate drive failure was flagged");

endmodule // gdfr_fault_regs

// file: gdfr_spi_master.sv
module gdfr_spi_master (
  // serial pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // frame engine
  // ---------------------------------------------------------------
  // sclk stands low outside frames, so cs edges always see it low
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b1;
  end

  // n other than 16 makes a broken frame on purpose
  task automatic xfer(input logic rw, input logic [3:0] addr, input logic [10:0] data,
                      input int n, output logic [10:0] rdata);
    logic [15:0] tx;
    logic [15:0] rx;
    tx     = {rw, addr, data};
    rx     = 16'h0000;
    cs_n_o = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      // data moves off the capture edge so the falling sclk never races it
      #5 sdi_o = tx[4'(15 - i)];
      #10 sclk_o = 1'b1;
      #15 rx = {rx[14:0], sdo_i};
      sclk_o = 1'b0;
    end
    // undriven data line: show the inverse rather than a stale bit
    #5 sdi_o = ~sdi_o;
    #10 cs_n_o = 1'b1;
    // covers the idle gap and the commit; every call lasts 24 core periods
    #(505 + 30 * (16 - n));
    rdata = rx[10:0];
  endtask
endmodule // gdfr_spi_master

// file: gdfr_fault_regs_tb_top.sv
module gdfr_fault_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import gdfr_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic             core_clk_i   = 1'b0;
  logic             rstn_i       = 1'b0;
  logic             enable_i     = 1'b0;
  gdfr_fault_t      faults_i     = '0;
  logic [10:0]      gate_sense_i = 11'h000;
  logic             sclk, cs_n, sdi, spi_sdo_o, spi_sdo_oe_o;
  logic             alarm_out_n_o, alarm_out_n_oe_o, latched_error_clear_o;
  logic [5:0][10:0] control_regs_o;
  logic [5:0][10:0] ns_ctrl;
  logic             ns_oe;
  logic             ns_oe_seen   = 1'b0;
  logic [10:0]      rv;
  int               err_count    = 0;
  int               total_checks = 0;
  int               clr_cnt      = 0;
  logic [5:0][10:0] pat = {11'h5a5, 11'h2aa, 11'h7f0, 11'h00f, 11'h555, 11'h0a6};
  // open drain with pull-up, both instances share it
  wire              sdo_w = (spi_sdo_oe_o | ns_oe) ? 1'b0 : 1'b1;

  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (latched_error_clear_o === 1'b1) clr_cnt++;
  always @(ns_oe) if (ns_oe === 1'b1) ns_oe_seen = 1'b1;

  gdfr_spi_master mst_u (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_w));

  gdfr_fault_regs dut_u (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .enable_i(enable_i), .faults_i(faults_i),
    .gate_sense_i(gate_sense_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_sdi_i(sdi),
    .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o), .alarm_out_n_o(alarm_out_n_o),
    .alarm_out_n_oe_o(alarm_out_n_oe_o), .control_regs_o(control_regs_o),
    .latched_error_clear_o(latched_error_clear_o));

  // hardware-configured variant on the same wires must stay deaf
  gdfr_fault_regs #(.HAS_SERIAL(1'b0)) ns_u (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .enable_i(enable_i), .faults_i(faults_i),
    .gate_sense_i(gate_sense_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_sdi_i(sdi),
    .spi_sdo_o(), .spi_sdo_oe_o(ns_oe), .alarm_out_n_o(), .alarm_out_n_oe_o(),
    .control_regs_o(ns_ctrl), .latched_error_clear_o());
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #5;
  endtask

  task automatic rd(input logic [3:0] a, input logic [10:0] exp);
    mst_u.xfer(READ_OP, a, 11'h000, 16, rv);
    chk(rv, exp);
  endtask

  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    mst_u.xfer(WRITE_OP, a, d, 16, rv);
  endtask

  task automatic fault_case(input gdfr_fault_t f, input logic [10:0] on, input logic [10:0] held);
    int n;
    faults_i = f;
    cyc(5);
    chk(11'(alarm_out_n_oe_o), 11'h001);
    chk(11'(alarm_out_n_o), 11'h000);
    rd(ADDR_PRIMARY_FAULT, on);
    faults_i = '0;
    cyc(5);
    rd(ADDR_PRIMARY_FAULT, held);
    n = clr_cnt;
    wr(ADDR_DRIVER_CTRL, pat[0] | 11'h001);
    chk(11'(clr_cnt - n), 11'h001);
    rd(ADDR_PRIMARY_FAULT, RST_STATUS);
    rd(ADDR_DRIVER_CTRL, pat[0]);
    chk(11'(alarm_out_n_oe_o), 11'h000);
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    #1ms;
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge core_clk_i);
    #5 rstn_i = 1'b1;
    enable_i = 1'b1;
    cyc(4);
    for (int i = 0; i < 6; i++) chk(control_regs_o[i], CTRL_RST[i]);
    rd(ADDR_PRIMARY_FAULT, RST_STATUS);
    rd(ADDR_GATE_SENSE, RST_STATUS);
    for (int i = 0; i < 6; i++) rd(ADDR_DRIVER_CTRL + 4'(i), CTRL_RST[i]);
    for (int i = 8; i < 16; i++) rd(4'(i), 11'h000);
    for (int i = 0; i < 6; i++) wr(ADDR_DRIVER_CTRL + 4'(i), pat[i]);
    for (int i = 0; i < 6; i++) rd(ADDR_DRIVER_CTRL + 4'(i), pat[i]);
    for (int i = 0; i < 6; i++) chk(control_regs_o[i], pat[i]);
    wr(ADDR_PRIMARY_FAULT, 11'h7ff);
    wr(ADDR_GATE_SENSE, 11'h7ff);
    rd(ADDR_PRIMARY_FAULT, RST_STATUS);
    rd(ADDR_GATE_SENSE, RST_STATUS);
    mst_u.xfer(WRITE_OP, ADDR_OCP_CTRL, 11'h000, 8, rv);
    rd(ADDR_OCP_CTRL, pat[3]);
    mst_u.xfer(WRITE_OP, ADDR_OCP_CTRL, 11'h000, 17, rv);
    rd(ADDR_OCP_CTRL, pat[3]);
    chk(ns_ctrl[1], RST_HS_DRIVE);
    chk(11'(ns_oe_seen), 11'h000);
    for (int i = 0; i < 6; i++) fault_case(9'h008 << i, 11'h600 | (11'h001 << i),
                                           11'h600 | (11'h001 << i));
    fault_case(9'h004, 11'h500, 11'h500);
    fault_case(9'h002, 11'h480, 11'h000);
    fault_case(9'h001, 11'h440, 11'h000);
    gate_sense_i = 11'h001;
    cyc(5);
    rd(ADDR_GATE_SENSE, 11'h001);
    rd(ADDR_PRIMARY_FAULT, 11'h400);
    gate_sense_i = 11'h080;
    cyc(5);
    rd(ADDR_PRIMARY_FAULT, 11'h400);
    wr(ADDR_DRIVER_CTRL, 11'h100);
    rd(ADDR_PRIMARY_FAULT, 11'h000);
    faults_i = 9'h004;
    cyc(5);
    rd(ADDR_PRIMARY_FAULT, 11'h000);
    faults_i = '0;
    gate_sense_i = 11'h000;
    enable_i = 1'b0;
    cyc(4);
    enable_i = 1'b1;
    cyc(4);
    for (int i = 0; i < 6; i++) chk(control_regs_o[i], CTRL_RST[i]);
    report_and_stop();
  end
endmodule // gdfr_fault_regs_tb_top
